/* File: src/xfer_test_wait_pkg.sv */
// package: opcodes, cycle counts, flag layout and carrier structs
package xfer_test_wait_pkg;

   // opcodes handled by this decoder
   localparam logic [7:0] OP_MOVE_ACC_TO_INDEX = 8'h97;
   localparam logic [7:0] OP_MOVE_INDEX_TO_ACC = 8'h9f;
   localparam logic [7:0] OP_TEST_DIRECT       = 8'h3d;
   localparam logic [7:0] OP_TEST_ACC          = 8'h4d;
   localparam logic [7:0] OP_TEST_INDEX        = 8'h5d;
   localparam logic [7:0] OP_TEST_IX_SHORT     = 8'h6d;
   localparam logic [7:0] OP_TEST_IX_NONE      = 8'h7d;
   localparam logic [7:0] OP_WAIT              = 8'h8f;

   // total cycles per instruction, opcode fetch included
   localparam logic [3:0] CYC_MOVE       = 4'h2;
   localparam logic [3:0] CYC_TEST_DIR   = 4'h4;
   localparam logic [3:0] CYC_TEST_REG   = 4'h3;
   localparam logic [3:0] CYC_TEST_IX1   = 4'h5;
   localparam logic [3:0] CYC_TEST_IX    = 4'h4;
   localparam logic [3:0] CYC_WAIT       = 4'h2;

   // condition code bit positions (h i n z c)
   localparam int CCR_C = 0;
   localparam int CCR_Z = 1;
   localparam int CCR_N = 2;
   localparam int CCR_I = 3;
   localparam int CCR_H = 4;

   // values after reset
   localparam logic [7:0]  RST_ACC   = 8'h00;
   localparam logic [7:0]  RST_INDEX = 8'h00;
   localparam logic [4:0]  RST_CCR   = 5'h08;  // interrupt mask set
   localparam logic [15:0] RST_ADDR  = 16'h0000;

   // addressing modes known to the address former
   typedef enum logic [2:0] {
      no_operand_mode,
      direct_mode,
      extended_address_mode,
      indexed_no_offset_mode,
      indexed_short_offset_mode,
      indexed_long_offset_mode
   } addr_mode_t;

   // operand bytes gathered for one instruction
   typedef struct packed {
      logic [7:0] first;   // direct addr, short offset or high byte
      logic [7:0] second;  // low byte (extended / long offset)
   } operand_bytes_t;

   // programmer visible registers
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] index;
      logic [4:0] ccr;
   } core_regs_t;

endpackage

/* File: src/operand_address_former.sv */
// module: forms the effective operand address from mode and operand bytes
`timescale 1ns/1ps
module operand_address_former (
   // mode and sources
   input  wire xfer_test_wait_pkg::addr_mode_t     mode_in,
   input  wire xfer_test_wait_pkg::operand_bytes_t bytes_in,
   input  wire logic [7:0]                         index_in,
   // result
   output logic [15:0]                             addr_out
);

   // purely combinational; the caller registers the result
   always_comb begin
      case (mode_in)
         xfer_test_wait_pkg::direct_mode: begin
            addr_out = {8'h00, bytes_in.first};
         end
         xfer_test_wait_pkg::extended_address_mode: begin
            addr_out = {bytes_in.first, bytes_in.second};
         end
         xfer_test_wait_pkg::indexed_no_offset_mode: begin
            addr_out = {8'h00, index_in};
         end
         xfer_test_wait_pkg::indexed_short_offset_mode: begin
            // unsigned offset, carry reaches the high byte
            addr_out = {8'h00, index_in}
                       + {8'h00, bytes_in.first};
         end
         xfer_test_wait_pkg::indexed_long_offset_mode: begin
            addr_out = {bytes_in.first, bytes_in.second}
                       + {8'h00, index_in};
         end
         default: begin
            addr_out = 16'h0000;
         end
      endcase
   end

endmodule

/* File: src/xfer_test_wait_decode.sv */
// module: decode and execution of transfer, test and wait instructions
// Notes on behaviour
// - 97 copies acc to index, 9f back; 2 cycles
// - test sets only n and z, no store
// - no-offset indexed uses index as address
// - short offset: index plus unsigned byte
// - long offset: high then low, plus index
// - extended address: high byte then low byte
// - bit branch: direct address then signed offset
`timescale 1ns/1ps
module xfer_test_wait_decode (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // instruction stream from fetch
   input  wire logic        byte_valid_in,   // fetch offers a byte
   input  wire logic [7:0]  byte_in,
   input  wire logic        bit_branch_in,   // opcode is a direct bit branch
   // memory read data
   input  wire logic [7:0]  mem_rdata_in,
   // wake sources
   input  wire logic        irq_in,
   // status
   output logic             byte_take_out,   // byte consumed at the previous edge
   output logic [15:0]      mem_addr_out,
   output logic             mem_rd_out,
   output logic [7:0]       acc_out,
   output logic [7:0]       index_out,
   output logic [4:0]       ccr_out,
   output logic [7:0]       branch_offset_out, // signed relative offset
   output logic             clk_halt_out,    // core clock gated off
   output logic             busy_out,
   output logic             illegal_out      // opcode outside this block
);

   // sequencer states
   typedef enum logic [2:0] {
      st_fetch, st_op1, st_op2, st_mem, st_exec, st_wait
   } state_t;

   // all state of the block
   typedef struct packed {
      state_t                         state;
      logic [7:0]                     opcode;
      logic [3:0]                     cyc;
      xfer_test_wait_pkg::core_regs_t regs;
      xfer_test_wait_pkg::operand_bytes_t ops;
      xfer_test_wait_pkg::addr_mode_t mode;
      logic [15:0]                    addr;
      logic                           rd;
      logic                           take;
      logic [7:0]                     rel;
      logic                           halt;
      logic                           illegal;
      logic                           busy;     // registered copy for the port
   } st_t;

   st_t s_q;  // registered state
   st_t s_d;  // next state

   logic [15:0] ea;  // effective address from the former

   // cycle count of a decoded opcode, zero for foreign opcodes
   function automatic logic [3:0] cycles_of(input logic [7:0] op);
      case (op)
         xfer_test_wait_pkg::OP_MOVE_ACC_TO_INDEX,
         xfer_test_wait_pkg::OP_MOVE_INDEX_TO_ACC:
            cycles_of = xfer_test_wait_pkg::CYC_MOVE;
         xfer_test_wait_pkg::OP_TEST_DIRECT:
            cycles_of = xfer_test_wait_pkg::CYC_TEST_DIR;
         xfer_test_wait_pkg::OP_TEST_ACC,
         xfer_test_wait_pkg::OP_TEST_INDEX:
            cycles_of = xfer_test_wait_pkg::CYC_TEST_REG;
         xfer_test_wait_pkg::OP_TEST_IX_SHORT:
            cycles_of = xfer_test_wait_pkg::CYC_TEST_IX1;
         xfer_test_wait_pkg::OP_TEST_IX_NONE:
            cycles_of = xfer_test_wait_pkg::CYC_TEST_IX;
         xfer_test_wait_pkg::OP_WAIT:
            cycles_of = xfer_test_wait_pkg::CYC_WAIT;
         default:
            cycles_of = 4'h0;
      endcase
   endfunction

   // addressing mode of a decoded opcode
   function automatic xfer_test_wait_pkg::addr_mode_t mode_of(
      input logic [7:0] op);
      case (op)
         xfer_test_wait_pkg::OP_TEST_DIRECT:
            mode_of = xfer_test_wait_pkg::direct_mode;
         xfer_test_wait_pkg::OP_TEST_IX_SHORT:
            mode_of = xfer_test_wait_pkg::indexed_short_offset_mode;
         xfer_test_wait_pkg::OP_TEST_IX_NONE:
            mode_of = xfer_test_wait_pkg::indexed_no_offset_mode;
         default:
            mode_of = xfer_test_wait_pkg::no_operand_mode;
      endcase
   endfunction

   // n and z from a value; test subtracts zero so value itself counts
   function automatic logic [4:0] nz_update(input logic [4:0] ccr,
                                            input logic [7:0] v);
      logic [4:0] r;
      r = ccr;
      r[xfer_test_wait_pkg::CCR_N] = v[7];
      r[xfer_test_wait_pkg::CCR_Z] = (v == 8'h00);
      nz_update = r;
   endfunction

   // address former shared by every memory mode
   operand_address_former u_addr (
      .mode_in  (s_q.mode),
      .bytes_in (s_q.ops),
      .index_in (s_q.regs.index),
      .addr_out (ea)
   );

   // next-state logic; cyc counts remaining cycles of the instruction
   always_comb begin
      s_d         = s_q;
      s_d.take    = 1'b0;
      s_d.rd      = 1'b0;
      s_d.illegal = 1'b0;
      if (s_q.cyc != 4'h0) begin
         s_d.cyc = s_q.cyc - 4'h1;
      end
      case (s_q.state)
         st_fetch: begin
            if (byte_valid_in) begin
               s_d.take   = 1'b1;
               s_d.opcode = byte_in;
               if (bit_branch_in) begin
                  // direct address then relative offset follow
                  s_d.mode  = xfer_test_wait_pkg::direct_mode;
                  s_d.state = st_op1;
                  s_d.cyc   = 4'h0;
               end else if (cycles_of(byte_in) == 4'h0) begin
                  s_d.illegal = 1'b1;  // left to other decoders
               end else begin
                  s_d.mode = mode_of(byte_in);
                  s_d.cyc  = cycles_of(byte_in) - 4'h1;
                  if (mode_of(byte_in) ==
                      xfer_test_wait_pkg::indexed_no_offset_mode) begin
                     s_d.state = st_mem;  // no operand byte
                  end else if (mode_of(byte_in) !=
                      xfer_test_wait_pkg::no_operand_mode) begin
                     s_d.state = st_op1;
                  end else begin
                     s_d.state = st_exec;
                  end
               end
            end
         end
         st_op1: begin
            // first operand byte: direct address or short offset
            if (byte_valid_in) begin
               s_d.take      = 1'b1;
               s_d.ops.first = byte_in;
               if (bit_branch_in || s_q.mode ==
                   xfer_test_wait_pkg::extended_address_mode ||
                   s_q.mode ==
                   xfer_test_wait_pkg::indexed_long_offset_mode) begin
                  s_d.state = st_op2;  // high byte taken first
               end else begin
                  s_d.state = st_mem;
               end
            end
         end
         st_op2: begin
            if (byte_valid_in) begin
               s_d.take = 1'b1;
               if (bit_branch_in) begin
                  s_d.rel   = byte_in;  // signed offset
                  s_d.state = st_fetch;
               end else begin
                  s_d.ops.second = byte_in;  // low byte
                  s_d.state      = st_mem;
               end
            end
         end
         st_mem: begin
            // present the formed address and request a read
            s_d.addr  = ea;
            s_d.rd    = 1'b1;
            s_d.state = st_exec;
         end
         st_exec: begin
            // hold until the documented cycle count has elapsed
            if (s_q.cyc <= 4'h1) begin
               s_d.state = st_fetch;
               s_d.cyc   = 4'h0;
               case (s_q.opcode)
                  xfer_test_wait_pkg::OP_MOVE_ACC_TO_INDEX: begin
                     s_d.regs.index = s_q.regs.acc;  // flags kept
                  end
                  xfer_test_wait_pkg::OP_MOVE_INDEX_TO_ACC: begin
                     s_d.regs.acc = s_q.regs.index;
                  end
                  xfer_test_wait_pkg::OP_TEST_ACC: begin
                     s_d.regs.ccr = nz_update(s_q.regs.ccr,
                                              s_q.regs.acc);
                  end
                  xfer_test_wait_pkg::OP_TEST_INDEX: begin
                     s_d.regs.ccr = nz_update(s_q.regs.ccr,
                                              s_q.regs.index);
                  end
                  xfer_test_wait_pkg::OP_WAIT: begin
                     // unmask and stop clock
                     s_d.regs.ccr[xfer_test_wait_pkg::CCR_I] = 1'b0;
                     s_d.halt  = 1'b1;
                     s_d.state = st_wait;
                  end
                  default: begin
                     // memory forms; nothing written back
                     s_d.regs.ccr = nz_update(s_q.regs.ccr,
                                              mem_rdata_in);
                  end
               endcase
            end
         end
         st_wait: begin
            // interrupt resumes; reset handled by the flops
            if (irq_in) begin
               s_d.halt  = 1'b0;
               s_d.state = st_fetch;
            end
         end
         default: begin
            s_d.state = st_fetch;
         end
      endcase
      // busy leaves a flop so the port carries no decode glitches
      s_d.busy = (s_d.state != st_fetch);
   end

   // state register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_q          <= '0;
         s_q.state    <= st_fetch;
         s_q.regs.acc   <= xfer_test_wait_pkg::RST_ACC;
         s_q.regs.index <= xfer_test_wait_pkg::RST_INDEX;
         s_q.regs.ccr   <= xfer_test_wait_pkg::RST_CCR;
         s_q.addr     <= xfer_test_wait_pkg::RST_ADDR;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign byte_take_out     = s_q.take;
   assign mem_addr_out      = s_q.addr;
   assign mem_rd_out        = s_q.rd;
   assign acc_out           = s_q.regs.acc;
   assign index_out         = s_q.regs.index;
   assign ccr_out           = s_q.regs.ccr;
   assign branch_offset_out = s_q.rel;
   assign clk_halt_out      = s_q.halt;
   assign busy_out          = s_q.busy;
   assign illegal_out       = s_q.illegal;

endmodule

/* File: test/xfer_test_wait_chk.sv */
// checker: timing and address relations of the decoder ports
`timescale 1ns/1ps
module xfer_test_wait_chk (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // stimulus side
   input  wire logic        byte_valid_in,
   input  wire logic [7:0]  byte_in,
   input  wire logic        irq_in,
   // design side
   input  wire logic        byte_take_out,
   input  wire logic [15:0] mem_addr_out,
   input  wire logic        mem_rd_out,
   input  wire logic [7:0]  acc_out,
   input  wire logic [7:0]  index_out,
   input  wire logic [4:0]  ccr_out,
   input  wire logic        clk_halt_out,
   input  wire logic        busy_out
);
   logic       take_w;  // opcode accepted at this edge
   logic [7:0] op_q;    // last opcode seen
   logic [7:0] opnd_q;  // first operand byte after it
   logic       want_q;  // next offered byte is an operand
   assign take_w = byte_valid_in && !busy_out && !clk_halt_out;
   // track opcode and operand; assumes operands follow back to back
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         op_q   <= 8'h00;
         opnd_q <= 8'h00;
         want_q <= 1'b0;
      end else if (take_w) begin
         op_q   <= byte_in;
         want_q <= 1'b1;
      end else begin
         if (want_q && byte_valid_in) begin
            opnd_q <= byte_in;
         end
         want_q <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_move_two_cycles: assert property (
      take_w && byte_in == 8'h97 |=>
      busy_out ##1 !busy_out && index_out == acc_out)
      else $error("move timing");
   a_move_flags_kept: assert property (
      take_w && (byte_in == 8'h97 || byte_in == 8'h9f) |=>
      $stable(ccr_out) [*2]) else $error("move flags");
   a_test_four_cycles: assert property (
      take_w && byte_in == 8'h7d |=> busy_out [*3] ##1 !busy_out)
      else $error("test cycle count");
   a_test_no_store: assert property (
      busy_out && op_q[3:0] == 4'hd |->
      $stable(acc_out) && $stable(index_out)) else $error("test stored");
   a_ix_none_addr: assert property (
      mem_rd_out && op_q == 8'h7d |-> mem_addr_out == {8'h00, index_out})
      else $error("no offset addr");
   a_ix_short_addr: assert property (
      mem_rd_out && op_q == 8'h6d |->
      mem_addr_out == {8'h00, index_out} + {8'h00, opnd_q})
      else $error("short offset addr");
   a_direct_addr: assert property (
      mem_rd_out && op_q == 8'h3d |-> mem_addr_out == {8'h00, opnd_q})
      else $error("direct addr");
   a_wait_halts: assert property (
      take_w && byte_in == 8'h8f |-> ##[1:2] clk_halt_out)
      else $error("wait did not halt");
   a_halt_mask_clear: assert property (
      clk_halt_out |-> !ccr_out[3]) else $error("mask set while halted");
   a_irq_wakes: assert property (
      clk_halt_out && irq_in |-> ##[1:3] !clk_halt_out)
      else $error("no wake");
   a_halt_refuses: assert property (
      clk_halt_out ##1 clk_halt_out |-> !byte_take_out)
      else $error("byte taken while halted");
   // main scenarios reached
   c_move: cover property (take_w && byte_in == 8'h97);
   c_short: cover property (mem_rd_out && op_q == 8'h6d);
   c_wake: cover property (clk_halt_out && irq_in);
endmodule
bind xfer_test_wait_decode xfer_test_wait_chk u_chk (.clk_in, .arst_n_in,
   .byte_valid_in, .byte_in, .irq_in, .byte_take_out, .mem_addr_out,
   .mem_rd_out, .acc_out, .index_out, .ccr_out, .clk_halt_out, .busy_out);

/* File: test/xfer_test_wait_decode_test.sv */
// testbench: drives the decoder ports and judges the results
`timescale 1ns/1ps
module xfer_test_wait_decode_test;
   // design inputs
   logic        clk_in        = 1'b0;
   logic        arst_n_in     = 1'b0;
   logic        byte_valid_in = 1'b0;
   logic [7:0]  byte_in       = 8'h00;
   logic        bit_branch_in = 1'b0;
   logic [7:0]  mem_rdata_in  = 8'h00;
   logic        irq_in        = 1'b0;
   // design outputs
   logic        byte_take_out;
   logic [15:0] mem_addr_out;
   logic        mem_rd_out;
   logic [7:0]  acc_out;
   logic [7:0]  index_out;
   logic [4:0]  ccr_out;
   logic [7:0]  branch_offset_out;
   logic        clk_halt_out;
   logic        busy_out;
   logic        illegal_out;
   // bookkeeping
   int          n_mismatch = 0;
   int          cmp_count  = 0;
   int          cycles     = 0;
   int          cyc;
   int          takes;
   int          ills;   // illegal pulses seen during one issue
   int          rds;    // read pulses seen during one issue
   always #12.5 clk_in = ~clk_in;
   xfer_test_wait_decode dut (.clk_in, .arst_n_in, .byte_valid_in, .byte_in,
      .bit_branch_in, .mem_rdata_in, .irq_in, .byte_take_out, .mem_addr_out,
      .mem_rd_out, .acc_out, .index_out, .ccr_out, .branch_offset_out,
      .clk_halt_out, .busy_out, .illegal_out);
   // verdict and end of run
   task automatic complete_run();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // hang guard, far above the hundred or so cycles needed
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // offer n bytes back to back; count takes and cycles to idle
   task automatic issue(input logic [7:0] op, b1, b2, input int n,
                        input logic bb);
      takes = 0;
      cyc   = 0;
      ills  = 0;
      rds   = 0;
      @(posedge clk_in);
      byte_valid_in <= 1'b1;
      byte_in       <= op;
      bit_branch_in <= bb;
      for (int i = 1; i <= 12; i++) begin
         @(posedge clk_in);
         if (byte_take_out === 1'b1) takes++;
         if (illegal_out === 1'b1) ills++;
         if (mem_rd_out === 1'b1) rds++;
         if (i < n) begin
            byte_in <= (i == 1) ? b1 : b2;
         end else begin
            byte_valid_in <= 1'b0;
            bit_branch_in <= 1'b0;
         end
         if (i > 1 && busy_out === 1'b0 && cyc == 0) cyc = i - 1;
         if (cyc != 0 && i > n) break;
      end
   endtask
   // moves between acc and index keep the flags
   task automatic s_move();
      issue(8'h4d, 8'h00, 8'h00, 1, 1'b0);
      chk("ccr z set", 16'h000a, 16'(ccr_out));
      issue(8'h97, 8'h00, 8'h00, 1, 1'b0);
      chk("move cycles", 16'h0002, 16'(cyc));
      chk("move decoded", 16'h0000, 16'(ills));
      chk("move ccr", 16'h000a, 16'(ccr_out));
      chk("index", 16'h0000, 16'(index_out));
      issue(8'h9f, 8'h00, 8'h00, 1, 1'b0);
      chk("back cycles", 16'h0002, 16'(cyc));
      chk("back ccr", 16'h000a, 16'(ccr_out));
   endtask
   // every test form: cycles, flags and operand address
   task automatic s_test();
      logic [7:0]  op [5] = '{8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d};
      logic [7:0]  ob [5] = '{8'h5a, 8'h00, 8'h00, 8'hc3, 8'h00};
      logic [7:0]  rd [5] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h80};
      logic [4:0]  fl [5] = '{5'h0c, 5'h0a, 5'h0a, 5'h0a, 5'h0c};
      logic [15:0] ad [5] = '{16'h005a, 16'h0, 16'h0, 16'h00c3, 16'h0};
      int          nb [5] = '{2, 1, 1, 2, 1};
      int          cy [5] = '{4, 3, 3, 5, 4};
      int          nr [5] = '{1, 0, 0, 1, 1};
      for (int i = 0; i < 5; i++) begin
         mem_rdata_in <= rd[i];
         issue(op[i], ob[i], 8'h00, nb[i], 1'b0);
         chk("test cycles", 16'(cy[i]), 16'(cyc));
         chk("test ccr", 16'(fl[i]), 16'(ccr_out));
         chk("test acc", 16'h0000, 16'(acc_out));
         chk("test reads", 16'(nr[i]), 16'(rds));
         if (nb[i] == 2 || i == 4) begin
            chk("addr", ad[i], mem_addr_out);
         end
      end
   endtask
   // bit branch gathers address then negative offset
   task automatic s_branch();
      issue(8'h00, 8'h44, 8'hf6, 3, 1'b1);
      chk("branch takes", 16'h0003, 16'(takes));
      chk("branch offset", 16'h00f6, 16'(branch_offset_out));
   endtask
   // opcode of another decoder is flagged and not executed
   task automatic s_foreign();
      issue(8'ha6, 8'h00, 8'h00, 1, 1'b0);
      chk("foreign flag", 16'h0001, 16'(ills));
      chk("foreign cycles", 16'h0001, 16'(cyc));
      chk("foreign reads", 16'h0000, 16'(rds));
   endtask
   // wait halts, refuses bytes, wakes on interrupt
   task automatic s_wait();
      issue(8'h8f, 8'h00, 8'h00, 1, 1'b0);
      chk("halt", 16'h0001, 16'(clk_halt_out));
      chk("mask", 16'h0000, 16'(ccr_out[3]));
      issue(8'h4d, 8'h4d, 8'h4d, 3, 1'b0);
      chk("halt takes", 16'h0000, 16'(takes));
      irq_in <= 1'b1;
      for (int i = 0; i < 10 && clk_halt_out !== 1'b0; i++) @(posedge clk_in);
      irq_in <= 1'b0;
      chk("woken", 16'h0000, 16'(clk_halt_out));
      issue(8'h4d, 8'h00, 8'h00, 1, 1'b0);
      chk("after wake", 16'h0003, 16'(cyc));
      // a reset in mid-run also ends the wait
      issue(8'h8f, 8'h00, 8'h00, 1, 1'b0);
      arst_n_in <= 1'b0;
      @(posedge clk_in);
      arst_n_in <= 1'b1;
      chk("reset wakes", 16'h0000, 16'(clk_halt_out));
      chk("reset mask", 16'h0008, 16'(ccr_out));
      issue(8'h4d, 8'h00, 8'h00, 1, 1'b0);
      chk("runs after reset", 16'h0003, 16'(cyc));
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      arst_n_in <= 1'b1;
      chk("reset ccr", 16'h0008, 16'(ccr_out));
      chk("reset halt", 16'h0000, 16'(clk_halt_out));
      s_move();
      s_test();
      s_branch();
      s_foreign();
      s_wait();
      complete_run();
   end
endmodule
